/* pmw_cfg.svh */
`ifndef PMW_CFG_SVH
`define PMW_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PMW_OFS_WAKE_TRAP   8'h00
`define PMW_OFS_DEV_STS     8'h04
`define PMW_OFS_GPIO_STS    8'h08
`define PMW_OFS_DEV_EN      8'h0C
`define PMW_OFS_GPIO_EN     8'h10
`define PMW_OFS_OUT_CTRL    8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMW_WAKE_BIT        7
`define PMW_TRAP_SER3_BIT   6
`define PMW_TRAP_PRT_BIT    3
`define PMW_TRAP_FDC_BIT    2
`define PMW_TRAP_SER1_BIT   1
`define PMW_TRAP_SER2_BIT   0
`define PMW_GPIO_WDT_BIT    4
`define PMW_GPIO_COMB_BIT   2
`define PMW_GPIO_PINA_BIT   1
`define PMW_GPIO_PINB_BIT   0
`define PMW_CTL_TYPE_BIT    2
`define PMW_CTL_FAST_BIT    1
`define PMW_CTL_OE_BIT      0

// ----------------------------------------------------------------
// Reset values and readable-bit masks
// ----------------------------------------------------------------
`define PMW_RST_REG         8'h00
`define PMW_MASK_WAKE_TRAP  8'hCF
`define PMW_MASK_DEV        8'h7F
`define PMW_MASK_GPIO       8'h17
`define PMW_MASK_CTRL       8'h07

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMW_CLK_KHZ         200000
`define PMW_SLOW_EXPIRY_MS  1000
`define PMW_FAST_EXPIRY_MS  8

`endif

/* pmw_flag_bank.sv */
`timescale 1ns/10ps

// Bank of sticky event flags; a set in the clearing cycle wins
module pmw_flag_bank #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  output logic      [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] flags_d;

  // Clear first, then set, so a coincident event is never lost
  always_comb begin
    flags_d = (flags_q & ~clr_i) | set_i;
  end

  // Flag storage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule : pmw_flag_bank

/* pmw_host_model.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Host chipset model: counts interrupt requests
// ----------------------------------------------------------------
module pmw_host_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       smi_n,
  input  wire logic       sci_n,
  output logic      [7:0] smi_cnt,
  output logic      [7:0] sci_cnt
);
  logic smi_q;
  logic sci_q;

  // Outputs are levels, so only a fresh fall is a new request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      smi_q   <= 1'b1;
      sci_q   <= 1'b1;
      smi_cnt <= 8'h00;
      sci_cnt <= 8'h00;
    end else begin
      smi_q   <= smi_n;
      sci_q   <= sci_n;
      smi_cnt <= smi_cnt + {7'h00, smi_q & ~smi_n};
      sci_cnt <= sci_cnt + {7'h00, sci_q & ~sci_n};
    end
  end
endmodule : pmw_host_model

/* pmw_pkg.sv */
package pmw_pkg;

  // Sleeping/working machine states
  typedef enum logic {
    PMW_SLEEPING,
    PMW_WORKING
  } pmw_pm_state_t;

  // One 8-bit configuration register image
  typedef logic [7:0] pmw_reg_t;

endpackage : pmw_pkg

/* pmw_wake_event_aggregator.sv */
`timescale 1ns/10ps
`include "pmw_cfg.svh"

// Contract
// - Wake flag sets on any resume while sleeping
// - Wake flag setting moves machine to working
// - Wake flag cleared by write-one or standby expiry
// - Trap flags set on wake; idle timer reloads
// - Trap flags clear on write one only
// - Serial trap sets on access, irq, start, modem
// - Printer trap sets on access, irq, ack, pins
// - Floppy trap sets on access, irq, ack, motor
// - Reserved bits read as zero
// - Device irq flags set by their source
// - Irq status flags clear on write one
// - Gpio flags: watchdog, combined, pin a, b
// - Output is OR of ten enabled flags
// - Device enables gate device flags onto output
// - Gpio enables gate gpio flags onto output, except pin a
// - Type select routes to management or control
// - Fast select picks one second or 8 ms
// - Output enable low suppresses both outputs
module pmw_wake_event_aggregator #(
  parameter int unsigned SLOW_EXPIRY_CYC = `PMW_SLOW_EXPIRY_MS * `PMW_CLK_KHZ,
  parameter int unsigned FAST_EXPIRY_CYC = `PMW_FAST_EXPIRY_MS * `PMW_CLK_KHZ
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        resume_event,
  input  wire logic        standby_expired,
  input  wire logic [2:0]  serial_access,
  input  wire logic [2:0]  serial_irq,
  input  wire logic [2:0]  serial_rx_start,
  input  wire logic [2:0]  serial_tx_start,
  input  wire logic [11:0] serial_modem_in,
  input  wire logic        printer_access,
  input  wire logic        printer_irq,
  input  wire logic        printer_dma_ack,
  input  wire logic [4:0]  printer_status_in,
  input  wire logic        floppy_access,
  input  wire logic        floppy_irq,
  input  wire logic        floppy_dma_ack,
  input  wire logic [3:0]  floppy_motor_enable,
  input  wire logic [6:0]  device_irq_src,
  input  wire logic [3:0]  gpio_irq_src,
  output logic             working_state,
  output logic [4:0]       idle_timer_reload,
  output logic             fast_expiry_select,
  output logic [31:0]      idle_expiry_cycles,
  output logic             system_management_interrupt_n,
  output logic             system_control_interrupt_n
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Byte-wide write-one-to-clear mask for a register hit
  function automatic logic [7:0] w1c_mask(input logic hit, input logic [31:0] data);
    w1c_mask = hit ? data[7:0] : 8'h00;
  endfunction : w1c_mask

  // Any level change between two samples
  function automatic logic changed(input logic [11:0] now, input logic [11:0] was);
    changed = |(now ^ was);
  endfunction : changed

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        acc, wr, mapped;
  logic        hit_wake, hit_dsts, hit_gsts, hit_den, hit_gen, hit_ctl;
  // Zero wait states; unknown addresses answer with an error
  always_comb begin
    hit_wake = (paddr == `PMW_OFS_WAKE_TRAP);
    hit_dsts = (paddr == `PMW_OFS_DEV_STS);
    hit_gsts = (paddr == `PMW_OFS_GPIO_STS);
    hit_den  = (paddr == `PMW_OFS_DEV_EN);
    hit_gen  = (paddr == `PMW_OFS_GPIO_EN);
    hit_ctl  = (paddr == `PMW_OFS_OUT_CTRL);
    mapped   = hit_wake | hit_dsts | hit_gsts | hit_den | hit_gen | hit_ctl;
    acc      = psel & penable;
    wr       = acc & pwrite & mapped;
    pready   = 1'b1;
    pslverr  = acc & ~mapped;
  end

  // ----------------------------------------------------------------
  // Wake flag and sleeping/working machine
  // ----------------------------------------------------------------
  pmw_pkg::pmw_pm_state_t state_q, state_d;
  logic                   wake_q, wake_set, wake_clr;

  // Only hardware sets the flag; set beats a coincident clear
  always_comb begin
    wake_set = (state_q == pmw_pkg::PMW_SLEEPING) & resume_event;
    wake_clr = (wr & hit_wake & pwdata[`PMW_WAKE_BIT]) | standby_expired;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_set | (wake_q & ~wake_clr);
    end
  end

  // Machine wakes with the flag and sleeps on standby expiry
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pmw_pkg::PMW_SLEEPING: begin
        if (wake_set) begin
          state_d = pmw_pkg::PMW_WORKING;
        end
      end
      pmw_pkg::PMW_WORKING: begin
        if (standby_expired) begin
          state_d = pmw_pkg::PMW_SLEEPING;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= pmw_pkg::PMW_SLEEPING;
    end else begin
      state_q <= state_d;
    end
  end

  assign working_state = (state_q == pmw_pkg::PMW_WORKING);

  // ----------------------------------------------------------------
  // Trap events
  // ----------------------------------------------------------------
  logic [11:0] modem_prev_q;
  logic [4:0]  prt_pins_prev_q, trap_set, trap_clr, trap_q;
  logic [3:0]  motor_prev_q;
  logic [2:0]  ser_wake;
  logic        prt_wake, fdc_wake;
  logic [7:0]  trap_wmask;
  // Previous pin samples for transition detection
  always_ff @(posedge core_clk) begin
    if (reset) begin
      modem_prev_q    <= 12'h000;
      prt_pins_prev_q <= 5'h00;
      motor_prev_q    <= 4'h0;
    end else begin
      modem_prev_q    <= serial_modem_in;
      prt_pins_prev_q <= printer_status_in;
      motor_prev_q    <= floppy_motor_enable;
    end
  end

  // Wake causes per peripheral; samples reset to zero, so nonzero pins count as an edge in the first cycle after reset
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ser_wake[i] = serial_access[i] | serial_irq[i] | serial_rx_start[i]
                  | serial_tx_start[i]
                  | changed({8'h00, serial_modem_in[4*i +: 4]},
                            {8'h00, modem_prev_q[4*i +: 4]});
    end
    prt_wake = printer_access | printer_irq | printer_dma_ack
             | changed({7'h00, printer_status_in}, {7'h00, prt_pins_prev_q});
    fdc_wake = floppy_access | floppy_irq | floppy_dma_ack
             | (|(floppy_motor_enable & ~motor_prev_q));
    // Order: third serial, printer, floppy, first serial, second serial
    trap_set = {ser_wake[2], prt_wake, fdc_wake, ser_wake[0], ser_wake[1]};
    trap_wmask = w1c_mask(wr & hit_wake, pwdata);
    trap_clr = {trap_wmask[`PMW_TRAP_SER3_BIT], trap_wmask[`PMW_TRAP_PRT_BIT],
                trap_wmask[`PMW_TRAP_FDC_BIT], trap_wmask[`PMW_TRAP_SER1_BIT],
                trap_wmask[`PMW_TRAP_SER2_BIT]};
  end

  // Software clearing while power management runs is unsupported
  pmw_flag_bank #(
    .WIDTH (5)
  ) u_trap_flags (
    .core_clk (core_clk),
    .reset    (reset),
    .set_i    (trap_set),
    .clr_i    (trap_clr),
    .flags_q  (trap_q)
  );

  // Reload pulse tells each idle timer to restart its expiry
  always_ff @(posedge core_clk) begin
    if (reset) begin
      idle_timer_reload <= 5'h00;
    end else begin
      idle_timer_reload <= trap_set;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status flags
  // ----------------------------------------------------------------
  logic [6:0] dev_q;
  logic [3:0] gpio_q, gpio_clr;
  logic [7:0] dev_wmask, gpio_wmask;
  // Write-one masks for both status banks
  always_comb begin
    dev_wmask  = w1c_mask(wr & hit_dsts, pwdata);
    gpio_wmask = w1c_mask(wr & hit_gsts, pwdata);
    gpio_clr   = {gpio_wmask[`PMW_GPIO_WDT_BIT], gpio_wmask[`PMW_GPIO_COMB_BIT],
                  gpio_wmask[`PMW_GPIO_PINA_BIT], gpio_wmask[`PMW_GPIO_PINB_BIT]};
  end

  pmw_flag_bank #(
    .WIDTH (7)
  ) u_dev_flags (
    .core_clk (core_clk),
    .reset    (reset),
    .set_i    (device_irq_src),
    .clr_i    (dev_wmask[6:0]),
    .flags_q  (dev_q)
  );

  // Source order: watchdog, combined, pin a, pin b
  pmw_flag_bank #(
    .WIDTH (4)
  ) u_gpio_flags (
    .core_clk (core_clk),
    .reset    (reset),
    .set_i    (gpio_irq_src),
    .clr_i    (gpio_clr),
    .flags_q  (gpio_q)
  );

  // ----------------------------------------------------------------
  // Enable and control registers
  // ----------------------------------------------------------------
  logic [6:0] dev_en_q;
  logic [3:0] gpio_en_q;
  logic [2:0] ctl_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dev_en_q  <= 7'h00;
      gpio_en_q <= 4'h0;
      ctl_q     <= 3'h0;
    end else if (wr) begin
      if (hit_den) begin
        dev_en_q <= pwdata[6:0];
      end
      if (hit_gen) begin
        gpio_en_q <= {pwdata[`PMW_GPIO_WDT_BIT], pwdata[`PMW_GPIO_COMB_BIT],
                      pwdata[`PMW_GPIO_PINA_BIT], pwdata[`PMW_GPIO_PINB_BIT]};
      end
      if (hit_ctl) begin
        ctl_q <= pwdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  logic irq_cond, fire;
  // Pin a has an enable but never reaches the output
  always_comb begin
    irq_cond = (|(dev_en_q & dev_q))
             | (gpio_en_q[3] & gpio_q[3]) | (gpio_en_q[2] & gpio_q[2])
             | (gpio_en_q[0] & gpio_q[0]);
    fire = irq_cond & ctl_q[`PMW_CTL_OE_BIT];
  end

  // Registered active-low levels; the select matters only when enabled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      system_management_interrupt_n <= 1'b1;
      system_control_interrupt_n    <= 1'b1;
    end else begin
      system_management_interrupt_n <= ~(fire & ~ctl_q[`PMW_CTL_TYPE_BIT]);
      system_control_interrupt_n    <= ~(fire & ctl_q[`PMW_CTL_TYPE_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Idle timer expiry select
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      idle_expiry_cycles <= SLOW_EXPIRY_CYC;
    end else begin
      idle_expiry_cycles <= ctl_q[`PMW_CTL_FAST_BIT] ? FAST_EXPIRY_CYC
                                                    : SLOW_EXPIRY_CYC;
    end
  end

  assign fast_expiry_select = ctl_q[`PMW_CTL_FAST_BIT];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_d, rd_q;
  // Reserved positions are never driven, so they read zero
  always_comb begin
    rd_d = `PMW_RST_REG;
    unique case (1'b1)
      hit_wake: rd_d = {wake_q, trap_q[4], 2'b00, trap_q[3:0]};
      hit_dsts: rd_d = {1'b0, dev_q};
      hit_gsts: rd_d = {3'b000, gpio_q[3], 1'b0, gpio_q[2:0]};
      hit_den:  rd_d = {1'b0, dev_en_q};
      hit_gen:  rd_d = {3'b000, gpio_en_q[3], 1'b0, gpio_en_q[2:0]};
      hit_ctl:  rd_d = {5'b00000, ctl_q};
      default:  rd_d = `PMW_RST_REG;
    endcase
  end

  // Captured in the setup cycle, stable through the access phase
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_q <= `PMW_RST_REG;
    end else if (psel & ~penable) begin
      rd_q <= rd_d;
    end
  end

  assign prdata = {24'h000000, rd_q};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  wake_sets_a: assert property ((state_q == pmw_pkg::PMW_SLEEPING) && resume_event
    |=> wake_q) else $error("wake flag did not set");
  wake_moves_a: assert property ($rose(wake_q) |-> working_state)
    else $error("machine not working after wake");
  wake_clear_a: assert property (wake_q && standby_expired && !wake_set |=> !wake_q)
    else $error("wake flag not cleared by expiry");
  trap_reload_a: assert property (trap_set != 5'h00 |=>
    ((trap_q & $past(trap_set)) == $past(trap_set)) && (idle_timer_reload == $past(trap_set)))
    else $error("trap flag or reload missing");
  trap_w1c_a: assert property (trap_clr != 5'h00 && trap_set == 5'h00
    |=> (trap_q & $past(trap_clr)) == 5'h00) else $error("trap flag not cleared");
  irq_w1c_a: assert property (dev_wmask != 8'h00 && device_irq_src == 7'h00
    |=> (dev_q & $past(dev_wmask[6:0])) == 7'h00) else $error("irq flag not cleared");
  reserved_zero_a: assert property (acc && !pwrite && hit_wake
    |-> prdata[5:4] == 2'b00) else $error("reserved bits not zero");
  smi_level_a: assert property (##1 system_management_interrupt_n
    == !$past(fire && !ctl_q[`PMW_CTL_TYPE_BIT])) else $error("management output wrong");
  oe_gates_a: assert property (!ctl_q[`PMW_CTL_OE_BIT] ##1 1'b1
    |-> system_management_interrupt_n && system_control_interrupt_n)
    else $error("output while disabled");
  expiry_sel_a: assert property (ctl_q[`PMW_CTL_FAST_BIT]
    |=> idle_expiry_cycles == FAST_EXPIRY_CYC) else $error("fast expiry wrong");

  wake_cycle_c: cover property (wake_set ##[1:20] standby_expired);
  smi_fire_c: cover property ($fell(system_management_interrupt_n));
  sci_fire_c: cover property ($fell(system_control_interrupt_n));
  race_clear_c: cover property (trap_set != 5'h00 && trap_clr != 5'h00);

endmodule : pmw_wake_event_aggregator

/* tb.sv */
`timescale 1ns/10ps
`include "pmw_cfg.svh"

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int unsigned SLOW = 100;
  localparam int unsigned FAST = 8;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        resume = 1'b0;
  logic        standby = 1'b0;
  logic [29:0] ev = 30'h0;
  logic [6:0]  dev_src = 7'h00;
  logic [3:0]  gpio_src = 4'h0;
  logic        clr = 1'b0;
  logic [4:0]  reload_seen = 5'h00;
  logic        pready, pslverr, working, fast_sel, smi_n, sci_n, se;
  logic [31:0] prdata, expiry;
  logic [4:0]  reload;
  logic [7:0]  smi_cnt, sci_cnt, rd;
  int          err_count = 0;
  int          checks = 0;

  // Short clock keeps the run small
  always #2.5 core_clk = ~core_clk;

  // Reload pulses last one cycle, so keep a sticky copy
  always @(posedge core_clk) reload_seen <= clr ? 5'h00 : reload_seen | reload;

  pmw_wake_event_aggregator #(.SLOW_EXPIRY_CYC(SLOW), .FAST_EXPIRY_CYC(FAST)) uut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .resume_event(resume),
    .standby_expired(standby), .serial_access(ev[2:0]), .serial_irq(ev[5:3]),
    .serial_rx_start(ev[8:6]), .serial_tx_start(ev[11:9]),
    .serial_modem_in({ev[14], 3'h0, ev[13], 3'h0, ev[12], 3'h0}),
    .printer_access(ev[15]), .printer_irq(ev[16]), .printer_dma_ack(ev[17]),
    .printer_status_in(ev[22:18]), .floppy_access(ev[23]), .floppy_irq(ev[24]),
    .floppy_dma_ack(ev[25]), .floppy_motor_enable(ev[29:26]),
    .device_irq_src(dev_src), .gpio_irq_src(gpio_src), .working_state(working),
    .idle_timer_reload(reload), .fast_expiry_select(fast_sel),
    .idle_expiry_cycles(expiry), .system_management_interrupt_n(smi_n),
    .system_control_interrupt_n(sci_n));

  pmw_host_model host (.core_clk(core_clk), .reset(reset), .smi_n(smi_n),
    .sci_n(sci_n), .smi_cnt(smi_cnt), .sci_cnt(sci_cnt));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      print_verdict();
    end
    rd = prdata[7:0];
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
    apb(1'b0, a, 8'h00);
    `CHK(n, e, rd)
    `CHK("upper bits", 24'h000000, prdata[31:8])
  endtask : rdchk

  task automatic pulse_pm(input logic sb);
    @(posedge core_clk);
    if (sb) standby <= 1'b1;
    else resume <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    resume <= 1'b0;
    cyc(2);
  endtask : pulse_pm

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) rdchk(8'(4 * i), 8'h00, "reset value");
    `CHK("idle state", 1'b0, working)
    apb(1'b0, 8'h18, 8'h00);
    `CHK("unmapped error", 1'b1, se)
    `CHK("unmapped data", 8'h00, rd)
    $display("test reset done");
  endtask : t_reset

  task automatic t_device;
    apb(1'b1, `PMW_OFS_OUT_CTRL, 8'h01);
    apb(1'b1, `PMW_OFS_DEV_EN, 8'hFF);
    rdchk(`PMW_OFS_DEV_EN, 8'h7F, "device enable");
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      dev_src <= 7'(1 << i);
      @(posedge core_clk);
      dev_src <= 7'h00;
      cyc(2);
      rdchk(`PMW_OFS_DEV_STS, 8'(1 << i), "device status");
      `CHK("smi asserted", 1'b0, smi_n)
      `CHK("sci idle", 1'b1, sci_n)
      `CHK("host smi count", 8'(i + 1), smi_cnt)
      apb(1'b1, `PMW_OFS_DEV_STS, 8'(1 << i));
      cyc(2);
      rdchk(`PMW_OFS_DEV_STS, 8'h00, "device cleared");
      `CHK("smi released", 1'b1, smi_n)
    end
    apb(1'b1, `PMW_OFS_DEV_EN, 8'h7E);
    @(posedge core_clk);
    dev_src <= 7'h01;
    @(posedge core_clk);
    dev_src <= 7'h00;
    cyc(2);
    rdchk(`PMW_OFS_DEV_STS, 8'h01, "masked status");
    `CHK("masked smi", 1'b1, smi_n)
    apb(1'b1, `PMW_OFS_DEV_STS, 8'h01);
    $display("test device done");
  endtask : t_device

  task automatic t_gpio;
    logic [7:0] e;
    apb(1'b1, `PMW_OFS_OUT_CTRL, 8'h05);
    apb(1'b1, `PMW_OFS_GPIO_EN, 8'hFF);
    rdchk(`PMW_OFS_GPIO_EN, 8'h17, "gpio enable");
    for (int j = 0; j < 4; j++) begin
      e = (j == 3) ? 8'h10 : 8'(1 << j);
      @(posedge core_clk);
      gpio_src <= 4'(1 << j);
      @(posedge core_clk);
      gpio_src <= 4'h0;
      cyc(2);
      rdchk(`PMW_OFS_GPIO_STS, e, "gpio status");
      `CHK("sci level", (j == 1), sci_n)
      `CHK("smi idle", 1'b1, smi_n)
      apb(1'b1, `PMW_OFS_GPIO_STS, e);
      cyc(2);
    end
    `CHK("host sci count", 8'h03, sci_cnt)
    @(posedge core_clk);
    gpio_src <= 4'h8;
    @(posedge core_clk);
    gpio_src <= 4'h0;
    apb(1'b1, `PMW_OFS_OUT_CTRL, 8'h04);
    cyc(2);
    `CHK("off sci", 1'b1, sci_n)
    `CHK("off smi", 1'b1, smi_n)
    rdchk(`PMW_OFS_GPIO_STS, 8'h10, "flag while off");
    apb(1'b1, `PMW_OFS_OUT_CTRL, 8'h05);
    cyc(2);
    `CHK("sci routed", 1'b0, sci_n)
    apb(1'b1, `PMW_OFS_GPIO_STS, 8'h10);
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_trap;
    logic [7:0] e;
    int idx;
    for (int k = 0; k < 30; k++) begin
      idx = (k < 12) ? k % 3 : k - 12;
      e = (idx == 0) ? 8'h02 : (idx == 1) ? 8'h01 : 8'h40;
      e = (k < 15) ? e : (k < 23) ? 8'h08 : 8'h04;
      @(posedge core_clk);
      ev <= 30'(1) << k;
      clr <= 1'b1;
      @(posedge core_clk);
      ev <= 30'h0;
      clr <= 1'b0;
      cyc(2);
      apb(1'b1, `PMW_OFS_WAKE_TRAP, 8'h00);
      rdchk(`PMW_OFS_WAKE_TRAP, e, "trap flag");
      `CHK("idle reload", {e[6], e[3:0]}, reload_seen)
      apb(1'b1, `PMW_OFS_WAKE_TRAP, e);
      rdchk(`PMW_OFS_WAKE_TRAP, 8'h00, "trap cleared");
    end
    $display("test trap done");
  endtask : t_trap

  task automatic t_wake;
    pulse_pm(1'b0);
    `CHK("working", 1'b1, working)
    rdchk(`PMW_OFS_WAKE_TRAP, 8'h80, "wake flag");
    apb(1'b1, `PMW_OFS_WAKE_TRAP, 8'h80);
    rdchk(`PMW_OFS_WAKE_TRAP, 8'h00, "wake cleared");
    pulse_pm(1'b0);
    rdchk(`PMW_OFS_WAKE_TRAP, 8'h00, "resume while working");
    pulse_pm(1'b1);
    `CHK("sleeping", 1'b0, working)
    pulse_pm(1'b0);
    rdchk(`PMW_OFS_WAKE_TRAP, 8'h80, "wake again");
    pulse_pm(1'b1);
    rdchk(`PMW_OFS_WAKE_TRAP, 8'h00, "standby clear");
    $display("test wake done");
  endtask : t_wake

  task automatic t_ctrl;
    apb(1'b1, `PMW_OFS_OUT_CTRL, 8'hFF);
    rdchk(`PMW_OFS_OUT_CTRL, 8'h07, "control");
    cyc(2);
    `CHK("fast select", 1'b1, fast_sel)
    `CHK("fast expiry", 32'(FAST), expiry)
    apb(1'b1, `PMW_OFS_OUT_CTRL, 8'h00);
    cyc(2);
    `CHK("slow expiry", 32'(SLOW), expiry)
    $display("test control done");
  endtask : t_ctrl

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_device();
    t_gpio();
    t_trap();
    t_wake();
    t_ctrl();
    print_verdict();
  end

  // A stuck run still ends with a verdict
  initial begin
    repeat (50000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
endmodule : tb
